// [rtl/nvd_regs.svh]
// constants for the non-volatile data memory access block
`ifndef NVD_REGS_SVH
`define NVD_REGS_SVH

// address windows of the data pages
`define NVD_XD_BASE    16'hfa00
`define NVD_SPI_BASE   16'h4400
`define NVD_SPI_LAST   16'h47ff
`define NVD_SPI_OFS    11'h200
// page sizes and layout of the data array
`define NVD_EXT_BYTES  11'h100
`define NVD_NORM_BYTES 11'h200
`define NVD_DATA_SIZE  1536
`define NVD_INFO_SIZE  512
// erase page numbers
`define NVD_PG_FIRST   6'h20
`define NVD_PG_LAST    6'h23
`define NVD_MAIN_PAGES 6'h20
// information page byte positions
`define NVD_INFO_UNPROTECTED_PAGE_COUNT  9'h020
`define NVD_INFO_RDIS  9'h023
// values
`define NVD_ERASED     8'hff
`define NVD_PROT_RST   8'hff
`define NVD_RDIS_SET   8'h00

`endif

// [rtl/nvd_pkg.sv]
// types shared by the non-volatile data memory access block
package nvd_pkg;

    // sequencer states
    typedef enum logic [1:0] {
        ST_LOAD_UNPROTECTED_PAGE_COUNT,
        ST_LOAD_RDIS,
        ST_IDLE,
        ST_ERASE
    } nvd_state_t;

endpackage : nvd_pkg

// [rtl/flash_nv_data_access.sv]
// non-volatile data memory access logic with start-up configuration load
`timescale 1ns/1ps
`default_nettype none
`include "nvd_regs.svh"

module flash_nv_data_access
    import nvd_pkg::*;
(
    // clock and reset
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    // core side, external data space
    input  wire logic        MCU_RD,
    input  wire logic        MCU_WR,
    input  wire logic        MCU_ERASE,
    input  wire logic [15:0] MCU_ADDR,
    input  wire logic [7:0]  MCU_WDATA,
    input  wire logic [5:0]  MCU_PAGE,
    input  wire logic        PROGRAM_MEMORY_WRITE_BIT,
    output var  logic [7:0]  MCU_RDATA,
    output var  logic        MCU_RVALID,
    output var  logic        MCU_ERR,
    // external programming side, decoded from the SPI slave
    input  wire logic        SPI_RD,
    input  wire logic        SPI_WR,
    input  wire logic        SPI_ERASE,
    input  wire logic        SPI_RDIS,
    input  wire logic        SPI_INFO,
    input  wire logic [15:0] SPI_ADDR,
    input  wire logic [7:0]  SPI_WDATA,
    input  wire logic [5:0]  SPI_PAGE,
    output var  logic [7:0]  SPI_RDATA,
    output var  logic        SPI_RVALID,
    output var  logic        SPI_ERR,
    // status and loaded configuration
    output var  logic        BUSY,
    output var  logic        READY,
    output var  logic [7:0]  FLASH_PROTECT_REGISTER,
    output var  logic        EXT_DISABLE
);

    // ************************************************************
    // storage and decode
    // ************************************************************
    // a blank part leaves the factory erased, so nothing loads unknown
    logic [7:0]  data_mem [`NVD_DATA_SIZE] = '{default: `NVD_ERASED};
    logic [7:0]  info_mem [`NVD_INFO_SIZE] = '{default: `NVD_ERASED};
    nvd_state_t  state_r;
    nvd_state_t  state_nxt;
    logic [10:0] erase_idx_r;
    logic [10:0] erase_last_r;
    logic        erase_info_r;
    logic [10:0] mcu_idx;
    logic [10:0] spi_idx;
    logic        idle;
    logic        mcu_req;
    logic        spi_req;
    logic        mcu_ok;
    logic        spi_ok;
    logic        mcu_rd_ok;
    logic        mcu_wr_ok;
    logic        mcu_er_ok;
    logic        spi_rd_ok;
    logic        spi_wr_ok;
    logic        spi_er_ok;
    logic        spi_rdis_ok;
    logic        mcu_addr_ok;
    logic        spi_addr_ok;

    // first array index of a data page
    function automatic logic [10:0] page_base(input logic [5:0] pg);
        case (pg[1:0])
            2'h0:    page_base = 11'h000;
            2'h1:    page_base = `NVD_EXT_BYTES;
            2'h2:    page_base = `NVD_NORM_BYTES;
            default: page_base = 11'h400;
        endcase
    endfunction : page_base

    // last array index of a data page
    function automatic logic [10:0] page_last(input logic [5:0] pg);
        page_last = page_base(pg) + (pg[1] ? `NVD_NORM_BYTES
                                           : `NVD_EXT_BYTES) - 11'h001;
    endfunction : page_last

    // only the four data pages are erasable here, code pages live elsewhere
    function automatic logic data_page(input logic [5:0] pg);
        data_page = (pg >= `NVD_PG_FIRST) && (pg <= `NVD_PG_LAST);
    endfunction : data_page

    // address maps of both requesters
    assign mcu_addr_ok = (MCU_ADDR >= `NVD_XD_BASE);
    assign mcu_idx     = 11'(MCU_ADDR - `NVD_XD_BASE);
    assign spi_addr_ok = (SPI_ADDR >= `NVD_SPI_BASE) &&
                         (SPI_ADDR <= `NVD_SPI_LAST);
    assign spi_idx     = 11'(SPI_ADDR - `NVD_SPI_BASE) + `NVD_SPI_OFS;

    // one request per cycle, the core wins a tie with SPI
    assign idle    = (state_r == ST_IDLE);
    assign mcu_req = MCU_RD | MCU_WR | MCU_ERASE;
    assign spi_req = SPI_RD | SPI_WR | SPI_ERASE | SPI_RDIS;

    // core requests: read over write over erase
    assign mcu_rd_ok = idle & MCU_RD & mcu_addr_ok;
    assign mcu_wr_ok = idle & ~MCU_RD & MCU_WR & mcu_addr_ok
                     & ~PROGRAM_MEMORY_WRITE_BIT;
    assign mcu_er_ok = idle & ~MCU_RD & ~MCU_WR & MCU_ERASE
                     & data_page(MCU_PAGE);
    assign mcu_ok    = mcu_rd_ok | mcu_wr_ok | mcu_er_ok;

    // SPI requests: the info page stays readable when access is blocked
    assign spi_rd_ok = idle & ~mcu_req & SPI_RD
                     & (SPI_INFO | (~EXT_DISABLE & spi_addr_ok));
    assign spi_wr_ok = idle & ~mcu_req & ~SPI_RD & SPI_WR & ~EXT_DISABLE
                     & (SPI_INFO | spi_addr_ok);
    assign spi_er_ok = idle & ~mcu_req & ~SPI_RD & ~SPI_WR & SPI_ERASE
                     & ~EXT_DISABLE & (SPI_INFO | data_page(SPI_PAGE));
    assign spi_rdis_ok = idle & ~mcu_req & ~SPI_RD & ~SPI_WR & ~SPI_ERASE
                       & SPI_RDIS & ~EXT_DISABLE;
    assign spi_ok    = spi_rd_ok | spi_wr_ok | spi_er_ok | spi_rdis_ok;

    // ************************************************************
    // sequencer
    // ************************************************************
    // next state: load two info bytes after reset, then serve requests
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_LOAD_UNPROTECTED_PAGE_COUNT: state_nxt = ST_LOAD_RDIS;
            ST_LOAD_RDIS: state_nxt = ST_IDLE;
            ST_IDLE: begin
                if (mcu_er_ok || spi_er_ok)
                    state_nxt = ST_ERASE;
            end
            ST_ERASE: begin
                if (erase_idx_r == erase_last_r)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_LOAD_UNPROTECTED_PAGE_COUNT;
        endcase
    end

    // state and status flops
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            state_r <= ST_LOAD_UNPROTECTED_PAGE_COUNT;
            BUSY    <= 1'b1;
            READY   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            BUSY    <= (state_nxt != ST_IDLE);
            READY   <= READY | (state_r == ST_LOAD_RDIS);
        end
    end

    // erase walker, one byte per clock so a normal page takes 512 cycles
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            erase_idx_r  <= 11'h000;
            erase_last_r <= 11'h000;
            erase_info_r <= 1'b0;
        end else if (mcu_er_ok) begin
            erase_idx_r  <= page_base(MCU_PAGE);
            erase_last_r <= page_last(MCU_PAGE);
            erase_info_r <= 1'b0;
        end else if (spi_er_ok) begin
            erase_idx_r  <= SPI_INFO ? 11'h000 : page_base(SPI_PAGE);
            erase_last_r <= SPI_INFO ? 11'h1ff : page_last(SPI_PAGE);
            erase_info_r <= SPI_INFO;
        end else if (state_r == ST_ERASE) begin
            erase_idx_r  <= erase_idx_r + 11'h001;
        end
    end

    // ************************************************************
    // memories
    // ************************************************************
    // flash only clears bits, so a second write without erase is unsafe
    always_ff @(posedge CLOCK) begin
        if (state_r == ST_ERASE && !erase_info_r)
            data_mem[erase_idx_r] <= `NVD_ERASED;
        else if (mcu_wr_ok)
            data_mem[mcu_idx] <= data_mem[mcu_idx] & MCU_WDATA;
        else if (spi_wr_ok && !SPI_INFO)
            data_mem[spi_idx] <= data_mem[spi_idx] & SPI_WDATA;
    end

    // information page, reachable only from SPI
    always_ff @(posedge CLOCK) begin
        if (state_r == ST_ERASE && erase_info_r)
            info_mem[erase_idx_r[8:0]] <= `NVD_ERASED;
        else if (spi_wr_ok && SPI_INFO)
            info_mem[SPI_ADDR[8:0]] <= info_mem[SPI_ADDR[8:0]] & SPI_WDATA;
        else if (spi_rdis_ok)
            info_mem[`NVD_INFO_RDIS] <= `NVD_RDIS_SET;
    end

    // ************************************************************
    // answers
    // ************************************************************
    // read data and strobes, one cycle after the request
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            MCU_RDATA  <= 8'h00;
            MCU_RVALID <= 1'b0;
            SPI_RDATA  <= 8'h00;
            SPI_RVALID <= 1'b0;
        end else begin
            MCU_RVALID <= mcu_rd_ok;
            SPI_RVALID <= spi_rd_ok;
            if (mcu_rd_ok)
                MCU_RDATA <= data_mem[mcu_idx];
            if (spi_rd_ok)
                SPI_RDATA <= SPI_INFO ? info_mem[SPI_ADDR[8:0]]
                                      : data_mem[spi_idx];
        end
    end

    // refusals: busy, unmapped, blocked or write bit still set
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            MCU_ERR <= 1'b0;
            SPI_ERR <= 1'b0;
        end else begin
            MCU_ERR <= mcu_req & ~mcu_ok;
            SPI_ERR <= spi_req & ~spi_ok;
        end
    end

    // configuration loaded from the info page; the block bit is sticky
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            FLASH_PROTECT_REGISTER <= `NVD_PROT_RST;
            EXT_DISABLE            <= 1'b0;
        end else begin
            if (state_r == ST_LOAD_UNPROTECTED_PAGE_COUNT)
                FLASH_PROTECT_REGISTER <= info_mem[`NVD_INFO_UNPROTECTED_PAGE_COUNT];
            if (state_r == ST_LOAD_RDIS)
                EXT_DISABLE <= (info_mem[`NVD_INFO_RDIS] != `NVD_ERASED);
            else if (spi_rdis_ok)
                EXT_DISABLE <= 1'b1;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    logic [7:0]  info_unprotected_page_count;
    logic [7:0]  info_rdis;
    logic [10:0] erased_idx_r;
    logic        erased_chk_r;
    logic [10:0] erase_cyc_r;
    logic        norm_erase_r;
    assign info_unprotected_page_count = info_mem[`NVD_INFO_UNPROTECTED_PAGE_COUNT];
    assign info_rdis = info_mem[`NVD_INFO_RDIS];

    // remembers the byte erased last cycle for the read-back check
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            erased_idx_r <= 11'h000;
            erased_chk_r <= 1'b0;
        end else begin
            erased_idx_r <= erase_idx_r;
            erased_chk_r <= (state_r == ST_ERASE) & ~erase_info_r;
        end
    end

    // counts busy cycles of a 512-byte erase, too long for a plain delay
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            erase_cyc_r  <= 11'h000;
            norm_erase_r <= 1'b0;
        end else if (mcu_er_ok || spi_er_ok) begin
            erase_cyc_r  <= 11'h000;
            norm_erase_r <= mcu_er_ok ? MCU_PAGE[1]
                                      : (SPI_INFO | SPI_PAGE[1]);
        end else if (BUSY) begin
            erase_cyc_r  <= erase_cyc_r + 11'h001;
        end else begin
            norm_erase_r <= 1'b0;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);

    sequence s_ext_erase;
        idle && MCU_ERASE && !MCU_RD && !MCU_WR && MCU_PAGE == 6'h20;
    endsequence
    sequence s_norm_erase;
        idle && MCU_ERASE && !MCU_RD && !MCU_WR && MCU_PAGE == 6'h22;
    endsequence

    property p_wr_bit_blocks;
        idle && MCU_WR && !MCU_RD && PROGRAM_MEMORY_WRITE_BIT
            |=> MCU_ERR;
    endproperty
    a_wr_bit_blocks: assert property (p_wr_bit_blocks)
        else $error("write with program-memory write bit set taken");

    property p_mcu_map;
        idle && MCU_RD && MCU_ADDR < 16'hfa00 |=> MCU_ERR && !MCU_RVALID;
    endproperty
    a_mcu_map: assert property (p_mcu_map)
        else $error("core read below data window answered");

    property p_spi_map;
        idle && !mcu_req && SPI_RD && !SPI_INFO && !EXT_DISABLE &&
        SPI_ADDR >= 16'h4400 && SPI_ADDR <= 16'h47ff |=> SPI_RVALID;
    endproperty
    a_spi_map: assert property (p_spi_map)
        else $error("mapped SPI read not answered");

    property p_ext_erase;
        s_ext_erase |-> ##256 BUSY ##1 !BUSY;
    endproperty
    a_ext_erase: assert property (p_ext_erase)
        else $error("extended page erase length wrong");

    property p_norm_erase;
        s_norm_erase |=> BUSY[*8];
    endproperty
    a_norm_erase: assert property (p_norm_erase)
        else $error("normal page erase not busy at once");

    property p_norm_len;
        norm_erase_r && $fell(BUSY) |-> erase_cyc_r == `NVD_NORM_BYTES;
    endproperty
    a_norm_len: assert property (p_norm_len)
        else $error("normal page erase length wrong");

    property p_code_page;
        idle && MCU_ERASE && !MCU_RD && !MCU_WR &&
        MCU_PAGE < `NVD_MAIN_PAGES |=> MCU_ERR && !BUSY;
    endproperty
    a_code_page: assert property (p_code_page)
        else $error("code page erase accepted by data logic");

    property p_ext_block;
        EXT_DISABLE && idle && !mcu_req && SPI_RD && !SPI_INFO
            |=> SPI_ERR && !SPI_RVALID;
    endproperty
    a_ext_block: assert property (p_ext_block)
        else $error("blocked external read answered");

    property p_load_unprotected_page_count;
        RST_N && state_r == ST_LOAD_UNPROTECTED_PAGE_COUNT |=>
            FLASH_PROTECT_REGISTER == $past(info_unprotected_page_count) ##1 READY;
    endproperty
    a_load_unprotected_page_count: assert property (p_load_unprotected_page_count)
        else $error("protect register not loaded at start-up");

    property p_load_rdis;
        state_r == ST_LOAD_RDIS |=>
            EXT_DISABLE == ($past(info_rdis) != 8'hff);
    endproperty
    a_load_rdis: assert property (p_load_rdis)
        else $error("block setting not loaded at start-up");

    property p_erased_ones;
        erased_chk_r |-> data_mem[erased_idx_r] == 8'hff;
    endproperty
    a_erased_ones: assert property (p_erased_ones)
        else $error("erased byte not all ones");

endmodule : flash_nv_data_access
`default_nettype wire

// [sim/nvd_host_model.sv]
// partner model: core and external programmer facing the access block
`timescale 1ns/1ps
`default_nettype none
module nvd_host_model (
    // clock
    input  wire logic        clk,
    // core requests
    output var  logic        mrd,
    output var  logic        mwr,
    output var  logic        mer,
    output var  logic [15:0] madr,
    output var  logic [7:0]  mwd,
    output var  logic [5:0]  mpg,
    output var  logic        program_memory_write_bit,
    // core answers
    input  wire logic [7:0]  mrdat,
    input  wire logic        mrv,
    input  wire logic        merr,
    // programmer requests
    output var  logic        srd,
    output var  logic        swr,
    output var  logic        ser,
    output var  logic        srdis,
    output var  logic        sinf,
    output var  logic [15:0] sadr,
    output var  logic [7:0]  swd,
    output var  logic [5:0]  spg,
    // programmer answers
    input  wire logic [7:0]  srdat,
    input  wire logic        srv,
    input  wire logic        serr
);
    // ***********************************************
    // request tasks, answer is {valid, refused, data}
    // ***********************************************

    // every request line idle from time zero
    initial begin
        {mrd, mwr, mer, program_memory_write_bit, srd, swr, ser, srdis, sinf} = 9'h000;
        {madr, sadr, mwd, swd, mpg, spg} = 60'h0;
    end

    // core request: op 0 read, 1 write, 2 erase with page in a[5:0]
    task automatic core_op(input logic [1:0] op, input logic [15:0] a,
                           input logic [7:0] d, input logic w,
                           output logic [9:0] ans);
        @(posedge clk);
        mrd  <= (op == 2'h0);
        mwr  <= (op == 2'h1);
        mer  <= (op == 2'h2);
        madr <= a;
        mwd  <= d;
        mpg  <= a[5:0];
        program_memory_write_bit  <= w;
        @(posedge clk);
        {mrd, mwr, mer} <= 3'h0;
        // released lines flip so a stale value never passes for live
        madr <= ~a;
        mwd  <= ~d;
        #1;
        ans = {mrv, merr, mrdat};
    endtask : core_op

    // programmer request: op 0 read, 1 write, 2 erase, 3 block access
    task automatic spi_op(input logic [1:0] op, input logic inf,
                          input logic [15:0] a, input logic [7:0] d,
                          output logic [9:0] ans);
        @(posedge clk);
        srd   <= (op == 2'h0);
        swr   <= (op == 2'h1);
        ser   <= (op == 2'h2);
        srdis <= (op == 2'h3);
        sinf  <= inf;
        sadr  <= a;
        swd   <= d;
        spg   <= a[5:0];
        @(posedge clk);
        {srd, swr, ser, srdis, sinf} <= 5'h00;
        sadr  <= ~a;
        swd   <= ~d;
        #1;
        ans = {srv, serr, srdat};
    endtask : spi_op
endmodule : nvd_host_model
`default_nettype wire

// [sim/tb_flash_nv_data_access.sv]
// testbench for the non-volatile data memory access block
`timescale 1ns/1ps
`default_nettype none
module tb_flash_nv_data_access;
    localparam int         LIMIT = 20000;
    localparam logic [9:0] REF   = 10'h100;
    localparam logic [9:0] TAKEN = 10'h000;
    logic        clk, rst_n, mrd, mwr, mer, program_memory_write_bit, mrv, merr, busy, ready;
    logic        srd, swr, ser, srdis, sinf, srv, serr, ext;
    logic [15:0] madr, sadr;
    logic [7:0]  mwd, swd, mrdat, srdat, fpr;
    logic [5:0]  mpg, spg;
    int          errors, num_checks, cycles;

    flash_nv_data_access i_dut (
        .CLOCK(clk), .RST_N(rst_n),
        .MCU_RD(mrd), .MCU_WR(mwr), .MCU_ERASE(mer), .MCU_ADDR(madr),
        .MCU_WDATA(mwd), .MCU_PAGE(mpg), .PROGRAM_MEMORY_WRITE_BIT(program_memory_write_bit),
        .MCU_RDATA(mrdat), .MCU_RVALID(mrv), .MCU_ERR(merr),
        .SPI_RD(srd), .SPI_WR(swr), .SPI_ERASE(ser), .SPI_RDIS(srdis),
        .SPI_INFO(sinf), .SPI_ADDR(sadr), .SPI_WDATA(swd), .SPI_PAGE(spg),
        .SPI_RDATA(srdat), .SPI_RVALID(srv), .SPI_ERR(serr),
        .BUSY(busy), .READY(ready), .FLASH_PROTECT_REGISTER(fpr),
        .EXT_DISABLE(ext)
    );
    nvd_host_model i_host (
        .clk, .mrd, .mwr, .mer, .madr, .mwd, .mpg, .program_memory_write_bit, .mrdat, .mrv,
        .merr, .srd, .swr, .ser, .srdis, .sinf, .sadr, .swd, .spg,
        .srdat, .srv, .serr
    );

    // ********************************
    // shared checking and bus helpers
    // ********************************

    always #2 clk = ~clk;

    // hang guard, ceiling well above the few thousand cycles needed
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            errors++;
            give_verdict();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        if (errors == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : give_verdict

    // read data is only defined for an accepted read, so it is skipped
    task automatic mc(input logic [1:0] op, input logic [15:0] a,
                      input logic [7:0] d, input logic w,
                      input logic [9:0] exp);
        logic [9:0] ans;
        i_host.core_op(op, a, d, w, ans);
        if (op == 2'h0 && !exp[8]) check(ans, exp);
        else check(ans[9:8], exp[9:8]);
    endtask : mc

    task automatic sp(input logic [1:0] op, input logic inf,
                      input logic [15:0] a, input logic [7:0] d,
                      input logic [9:0] exp);
        logic [9:0] ans;
        i_host.spi_op(op, inf, a, d, ans);
        if (op == 2'h0 && !exp[8]) check(ans, exp);
        else check(ans[9:8], exp[9:8]);
    endtask : sp

    // counts busy cycles still to come, entered one cycle after the take
    task automatic wait_busy(input int exp);
        int n;
        n = 0;
        while (busy === 1'b1 && n < 1000) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(n), 16'(exp));
    endtask : wait_busy

    task automatic do_reset(input logic chk, input logic [7:0] fp,
                            input logic ex);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check({busy, ready, fpr, ext}, {2'h2, 8'hff, 1'b0});
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        check({busy, ready}, 2'h2);
        @(posedge clk);
        #1;
        check({busy, ready}, 2'h1);
        if (chk) check({fpr, ext}, {fp, ex});
    endtask : do_reset

    // ********************************
    // scenarios
    // ********************************

    task automatic t_info;
        sp(2'h2, 1'b1, 16'h0, 8'h0, TAKEN);
        wait_busy(512);
        sp(2'h0, 1'b1, 16'h020, 8'h0, {2'h2, 8'hff});
        do_reset(1'b1, 8'hff, 1'b0);
        sp(2'h1, 1'b1, 16'h020, 8'h0c, TAKEN);
        sp(2'h0, 1'b1, 16'h020, 8'h0, {2'h2, 8'h0c});
        do_reset(1'b1, 8'h0c, 1'b0);
    endtask : t_info

    // each data page erased from alternate sides, edges read back blank
    task automatic t_erase;
        logic [15:0] base [4] = '{16'hfa00, 16'hfb00, 16'hfc00, 16'hfe00};
        for (int i = 0; i < 4; i++) begin
            if (i[0]) sp(2'h2, 1'b0, 16'(32 + i), 8'h0, TAKEN);
            else mc(2'h2, 16'(32 + i), 8'h0, 1'b0, TAKEN);
            wait_busy(i < 2 ? 256 : 512);
            mc(2'h0, base[i], 8'h0, 1'b0, {2'h2, 8'hff});
            mc(2'h0, base[i] + (i < 2 ? 16'hff : 16'h1ff), 8'h0, 1'b0,
               {2'h2, 8'hff});
        end
        sp(2'h0, 1'b1, 16'h020, 8'h0, {2'h2, 8'h0c});
    endtask : t_erase

    task automatic t_refuse;
        mc(2'h1, 16'hfc06, 8'h00, 1'b1, REF);
        mc(2'h0, 16'hfc06, 8'h0, 1'b0, {2'h2, 8'hff});
        mc(2'h0, 16'hf9ff, 8'h0, 1'b0, REF);
        sp(2'h0, 1'b0, 16'h43ff, 8'h0, REF);
        sp(2'h0, 1'b0, 16'h4800, 8'h0, REF);
        mc(2'h2, 16'h001f, 8'h0, 1'b0, REF);
        mc(2'h2, 16'h0024, 8'h0, 1'b0, REF);
        sp(2'h2, 1'b0, 16'h0024, 8'h0, REF);
        mc(2'h2, 16'h0020, 8'h0, 1'b0, TAKEN);
        mc(2'h0, 16'hfa00, 8'h0, 1'b0, REF);
        wait_busy(254);
    endtask : t_refuse

    task automatic t_map;
        mc(2'h1, 16'hfc05, 8'h3c, 1'b0, TAKEN);
        sp(2'h0, 1'b0, 16'h4405, 8'h0, {2'h2, 8'h3c});
        sp(2'h1, 1'b0, 16'h47ff, 8'ha5, TAKEN);
        mc(2'h0, 16'hffff, 8'h0, 1'b0, {2'h2, 8'ha5});
        mc(2'h1, 16'hfaff, 8'h11, 1'b0, TAKEN);
        mc(2'h0, 16'hfb00, 8'h0, 1'b0, {2'h2, 8'hff});
        mc(2'h0, 16'hfaff, 8'h0, 1'b0, {2'h2, 8'h11});
    endtask : t_map

    // blocking is one-way, so it runs last and survives a reset
    task automatic t_block;
        sp(2'h3, 1'b0, 16'h0, 8'h0, TAKEN);
        check(ext, 1'b1);
        sp(2'h0, 1'b0, 16'h4405, 8'h0, REF);
        sp(2'h1, 1'b0, 16'h4406, 8'h00, REF);
        sp(2'h0, 1'b1, 16'h023, 8'h0, {2'h2, 8'h00});
        mc(2'h0, 16'hfc05, 8'h0, 1'b0, {2'h2, 8'h3c});
        do_reset(1'b1, 8'h0c, 1'b1);
        sp(2'h0, 1'b0, 16'h4405, 8'h0, REF);
    endtask : t_block

    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        errors = 0;
        num_checks = 0;
        cycles = 0;
        do_reset(1'b0, 8'h00, 1'b0);
        t_info();
        t_erase();
        t_refuse();
        t_map();
        t_block();
        give_verdict();
    end
endmodule : tb_flash_nv_data_access
`default_nettype wire
